// File: logic/bsas_consts.svh
// Purpose: Constants for the boot start address select block
// Assumes: 200 MHz core clock
// Notes:   Times kept in their own units; cycle counts derived
`ifndef BSAS_CONSTS_SVH
`define BSAS_CONSTS_SVH

`define BSAS_CLK_MHZ          200
`define BSAS_APP_ORIGIN       16'h0000
`define BSAS_VEC_LOW_BYTE     8'h00
`define BSAS_VEC_DEF_SMALL    8'h0f
`define BSAS_VEC_DEF_MID      8'h1f
`define BSAS_VEC_DEF_LARGE    8'h3f
`define BSAS_LOADER_BYTES     16'h0200
`define BSAS_SECTOR_BYTES     16'h0400
`define BSAS_PAGE_TOP         8'hff
`define BSAS_ADDR_STEP        16'h0001
`define BSAS_BASE_RST         16'h0000
`define BSAS_SIZE_SMALL       2'h0
`define BSAS_SIZE_MID         2'h1
`define BSAS_SIZE_LARGE       2'h2
// Serial programming entry pulse timing
`define BSAS_T_VR_US          50
`define BSAS_T_RH_MIN_US      1
`define BSAS_T_RH_MAX_US      32
`define BSAS_T_RL_MIN_US      1
`define BSAS_T_VR_CYC         (`BSAS_T_VR_US * `BSAS_CLK_MHZ)
`define BSAS_T_RH_MIN_CYC     (`BSAS_T_RH_MIN_US * `BSAS_CLK_MHZ)
`define BSAS_T_RH_MAX_CYC     (`BSAS_T_RH_MAX_US * `BSAS_CLK_MHZ)
`define BSAS_T_RL_MIN_CYC     (`BSAS_T_RL_MIN_US * `BSAS_CLK_MHZ)
`define BSAS_CNT_W            14
`define BSAS_CNT_SAT          14'h3fff
`define BSAS_CNT_FIRST        14'h0001

`endif

// File: logic/bsas_pkg.sv
// Purpose: Types for the boot start address select block
// Assumes: Constants come from bsas_consts.svh
// Notes:   One-hot state codes written out
package bsas_pkg;
    typedef logic [15:0] bsas_addr_t;
    typedef logic [7:0]  bsas_byte_t;

    typedef enum logic [3:0] {
        BSAS_IDLE   = 4'b0001,
        BSAS_SAMPLE = 4'b0010,
        BSAS_LOAD   = 4'b0100,
        BSAS_RUN    = 4'b1000
    } bsas_state_e;

    typedef enum logic [3:0] {
        BSAS_PW_POWER = 4'b0001,
        BSAS_PW_LOW   = 4'b0010,
        BSAS_PW_HIGH  = 4'b0100,
        BSAS_PW_DONE  = 4'b1000
    } bsas_pulse_e;
endpackage : bsas_pkg

// File: logic/bsas_entry_detect.sv
// Purpose: Detect the reset pulse that requests serial programming mode
// Assumes: Pin level synchronous to clock, high means reset asserted
// Notes:   Result holds until power is removed
`timescale 1ns/1ps
`include "bsas_consts.svh"
module bsas_entry_detect
    import bsas_pkg::*;
(
    // Clock and power reset
    input  wire logic clock,
    input  wire logic sys_rst,
    // Pin
    input  wire logic rst_pin,
    // Result
    output logic      serial_programming_mode
);
    typedef struct packed {
        bsas_pulse_e              st;
        logic [`BSAS_CNT_W-1:0]   cnt;
        logic                     hit;
    } bsas_det_s;

    bsas_det_s det_reg;
    bsas_det_s det_next;

    // ==========================================================
    // Pulse width checker
    always_comb begin
        det_next = det_reg;
        if (det_reg.cnt != `BSAS_CNT_SAT) begin
            det_next.cnt = det_reg.cnt + 1'b1;
        end
        case (det_reg.st)
            BSAS_PW_POWER: begin
                // Pulses before supply settles are ignored
                if (det_reg.cnt >= `BSAS_CNT_W'(`BSAS_T_VR_CYC)) begin
                    if (rst_pin) begin
                        det_next.st  = BSAS_PW_HIGH;
                        // This edge already saw one high sample
                        det_next.cnt = `BSAS_CNT_FIRST;
                    end
                end
            end
            BSAS_PW_HIGH: begin
                if (!rst_pin) begin
                    if (det_reg.cnt >= `BSAS_CNT_W'(`BSAS_T_RH_MIN_CYC) &&
                        det_reg.cnt <= `BSAS_CNT_W'(`BSAS_T_RH_MAX_CYC)) begin
                        det_next.st = BSAS_PW_LOW;
                    end else begin
                        det_next.st = BSAS_PW_DONE;
                    end
                    // Count the first low sample; the pin must still be low once 1 us is counted
                    det_next.cnt = `BSAS_CNT_FIRST;
                end
            end
            BSAS_PW_LOW: begin
                if (rst_pin) begin
                    det_next.st = BSAS_PW_DONE;
                end else if (det_reg.cnt >= `BSAS_CNT_W'(`BSAS_T_RL_MIN_CYC)) begin
                    det_next.hit = 1'b1;
                    det_next.st  = BSAS_PW_DONE;
                end
            end
            BSAS_PW_DONE: begin
                det_next.cnt = det_reg.cnt;
            end
            default: begin
                det_next.st = BSAS_PW_DONE;
            end
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            det_reg.st  <= BSAS_PW_POWER;
            det_reg.cnt <= '0;
            det_reg.hit <= 1'b0;
        end else begin
            det_reg <= det_next;
        end
    end

    assign serial_programming_mode = det_reg.hit;
endmodule : bsas_entry_detect

// File: logic/bsas_select.sv
// Purpose: Choose the processor start address after every reset
// Assumes: Flag and vector are non-volatile cells, stable while read
// Notes:   Loader region is plain code space; erase protection is absent
`timescale 1ns/1ps
`include "bsas_consts.svh"

// Overview of operation
// - After reset, read the boot status flag before the first fetch.
// - Flag zero starts execution at address 0000H.
// - Flag nonzero uses vector as high byte, low byte 00H.
// - Factory vector is 0FH, 1FH or 3FH by memory size.
// - Factory loader fills top 512 bytes inside a top 1 kB sector.
// - Loader region is not erase protected; erases remove it.
// - Programmable vector redirects reset to a custom loader.
// - Default vector points at the serial programming loader.
module bsas_select
    import bsas_pkg::*;
(
    // Clock and reset
    input  wire logic          clock,
    input  wire logic          sys_rst,
    // Device reset request and pin
    input  wire logic          core_rst,
    input  wire logic          rst_pin,
    // Non-volatile boot cells
    input  wire logic          boot_status,
    input  wire bsas_pkg::bsas_byte_t boot_vector,
    input  wire logic [1:0]    mem_size,
    // Core side
    output bsas_pkg::bsas_addr_t start_addr,
    output logic               pc_load,
    output logic               fetch_enable,
    output bsas_pkg::bsas_byte_t default_vector,
    output bsas_pkg::bsas_addr_t loader_base,
    output bsas_pkg::bsas_addr_t sector_base,
    output logic               boot_to_loader,
    output logic               serial_programming_mode
);
    typedef struct packed {
        bsas_state_e st;
        bsas_addr_t  addr;
        logic        load;
        logic        run;
        bsas_byte_t  defv;
        bsas_addr_t  ldr;
        bsas_addr_t  sec;
        logic        to_ldr;
        logic        spm;
    } bsas_sel_s;

    bsas_sel_s s_reg;
    bsas_sel_s s_next;
    logic      entry_hit;
    bsas_addr_t top_addr;

    // ==========================================================
    // Serial programming entry
    bsas_entry_detect u_entry (
        .clock                   (clock),
        .sys_rst                 (sys_rst),
        .rst_pin                 (rst_pin),
        .serial_programming_mode (entry_hit)
    );

    // ==========================================================
    // Selection sequence
    always_comb begin
        s_next      = s_reg;
        s_next.load = 1'b0;
        s_next.spm  = entry_hit;
        top_addr    = {s_reg.defv, `BSAS_PAGE_TOP};
        case (mem_size)
            `BSAS_SIZE_SMALL: s_next.defv = `BSAS_VEC_DEF_SMALL;
            `BSAS_SIZE_MID:   s_next.defv = `BSAS_VEC_DEF_MID;
            default:          s_next.defv = `BSAS_VEC_DEF_LARGE;
        endcase
        // Loader and sector sit at the top of code space; no lock applied
        s_next.ldr = top_addr - `BSAS_LOADER_BYTES + `BSAS_ADDR_STEP;
        s_next.sec = top_addr - `BSAS_SECTOR_BYTES + `BSAS_ADDR_STEP;
        case (s_reg.st)
            BSAS_IDLE: begin
                s_next.run = 1'b0;
                if (!core_rst) begin
                    s_next.st = BSAS_SAMPLE;
                end
            end
            BSAS_SAMPLE: begin
                // Flag read while fetch is still held off
                if (boot_status == 1'b0) begin
                    s_next.addr   = `BSAS_APP_ORIGIN;
                    s_next.to_ldr = 1'b0;
                end else begin
                    s_next.addr   = {boot_vector, `BSAS_VEC_LOW_BYTE};
                    s_next.to_ldr = (boot_vector == s_reg.defv);
                end
                s_next.st = BSAS_LOAD;
            end
            BSAS_LOAD: begin
                s_next.load = 1'b1;
                s_next.st   = BSAS_RUN;
            end
            BSAS_RUN: begin
                s_next.run = 1'b1;
            end
            default: begin
                s_next.st = BSAS_IDLE;
            end
        endcase
        // Any device reset restarts selection
        if (core_rst) begin
            s_next.st   = BSAS_IDLE;
            s_next.run  = 1'b0;
            s_next.load = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s_reg.st     <= BSAS_IDLE;
            s_reg.addr   <= `BSAS_APP_ORIGIN;
            s_reg.load   <= 1'b0;
            s_reg.run    <= 1'b0;
            s_reg.defv   <= `BSAS_VEC_DEF_LARGE;
            s_reg.ldr    <= `BSAS_BASE_RST;
            s_reg.sec    <= `BSAS_BASE_RST;
            s_reg.to_ldr <= 1'b0;
            s_reg.spm    <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign start_addr              = s_reg.addr;
    assign pc_load                 = s_reg.load;
    assign fetch_enable            = s_reg.run;
    assign default_vector          = s_reg.defv;
    assign loader_base             = s_reg.ldr;
    assign sector_base             = s_reg.sec;
    assign boot_to_loader          = s_reg.to_ldr;
    assign serial_programming_mode = s_reg.spm;
endmodule : bsas_select

// File: tb/bsas_checker.sv
// Purpose: Port checks for the start address select block
// Assumes: Bound to bsas_select, inputs held while a selection runs
// Notes:   Lags follow the selection sequence
`timescale 1ns/1ps
module bsas_checker
    import bsas_pkg::*;
(
    // Watched ports
    input wire logic                 clock,
    input wire logic                 sys_rst,
    input wire logic                 core_rst,
    input wire logic                 rst_pin,
    input wire logic                 boot_status,
    input wire bsas_pkg::bsas_byte_t boot_vector,
    input wire logic [1:0]           mem_size,
    input wire bsas_pkg::bsas_addr_t start_addr,
    input wire logic                 pc_load,
    input wire logic                 fetch_enable,
    input wire bsas_pkg::bsas_byte_t default_vector,
    input wire bsas_pkg::bsas_addr_t loader_base,
    input wire bsas_pkg::bsas_addr_t sector_base,
    input wire logic                 boot_to_loader,
    input wire logic                 serial_programming_mode
);
    default clocking @(posedge clock); endclocking
    logic rst_tail_reg;
    // Attempts launched on the release edge still see reset state
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rst_tail_reg <= 1'b1;
        end else begin
            rst_tail_reg <= 1'b0;
        end
    end
    default disable iff (sys_rst || rst_tail_reg);
    // ==========
    // Selection and serial programming entry
    app_origin_a: assert property (pc_load && !boot_status |-> start_addr == 16'h0000)
        else $error("start address not origin");
    vector_high_a: assert property (pc_load && boot_status |-> start_addr == {boot_vector, 8'h00})
        else $error("start address not vector page");
    pulse_one_a: assert property (pc_load |=> !pc_load)
        else $error("load pulse too long");
    load_first_a: assert property ($rose(fetch_enable) |-> $past(pc_load))
        else $error("fetch before load");
    abort_clear_a: assert property (core_rst [*2] |-> !fetch_enable && !pc_load)
        else $error("reset did not stop core");
    rerun_sel_a: assert property ($fell(core_rst) |-> ##[1:4] (pc_load || core_rst))
        else $error("no selection after reset");
    vec_small_a: assert property (mem_size == 2'h0 |=> default_vector == 8'h0f)
        else $error("wrong small vector");
    loader_span_a: assert property (mem_size == 2'h1 [*3] |-> loader_base == 16'h1e00 &&
        sector_base == 16'h1c00)
        else $error("wrong loader bases");
    loader_flag_a: assert property (pc_load |-> boot_to_loader ==
        (boot_status && boot_vector == default_vector))
        else $error("wrong loader indication");
    entry_hold_a: assert property (serial_programming_mode |=> serial_programming_mode)
        else $error("entry mode dropped");
    entry_low_a: assert property ($rose(serial_programming_mode) |-> !$past(rst_pin, 8))
        else $error("entry before pin low");
    cover property (pc_load && boot_status);
    cover property (pc_load && !boot_status);
    cover property ($rose(serial_programming_mode));
endmodule : bsas_checker

// File: tb/bsas_programmer.sv
// Purpose: Programmer model pulsing the reset pin
// Assumes: go lasts one cycle
// Notes:   Pin released low; lead-in wait is the bench's job
`timescale 1ns/1ps
module bsas_programmer (
    // Request
    input wire logic        clock,
    input wire logic        go,
    input wire logic [12:0] hi_len,
    // Pin
    output logic            rst_pin
);
    int left = 0;
    initial rst_pin = 1'b0;
    always @(posedge clock) begin
        if (go) begin
            rst_pin <= 1'b1;
            left <= hi_len - 1;
        end else if (left > 0) begin
            left <= left - 1;
        end else begin
            rst_pin <= 1'b0;
        end
    end
endmodule : bsas_programmer

// File: tb/bsas_select_tb.sv
// Purpose: Self-checking bench for the start address select block
// Assumes: 200 MHz clock, stimulus on the rising edge
// Notes:   Entry timing kept at full cycle counts
`timescale 1ns/1ps
module bsas_select_tb;
    import bsas_pkg::*;
    logic clock = 0, sys_rst = 1, core_rst = 1, boot_status = 0, go = 0, rst_pin;
    logic [1:0] mem_size = 0;
    logic [12:0] hi_len = 0;
    bsas_byte_t boot_vector = 0, default_vector;
    bsas_addr_t start_addr, loader_base, sector_base;
    logic pc_load, fetch_enable, boot_to_loader, spm;
    int err_count = 0, cmp_count = 0;
    always #2.5 clock = ~clock;
    bsas_select DUT (.clock(clock), .sys_rst(sys_rst), .core_rst(core_rst), .rst_pin(rst_pin),
        .boot_status(boot_status), .boot_vector(boot_vector), .mem_size(mem_size),
        .start_addr(start_addr), .pc_load(pc_load), .fetch_enable(fetch_enable),
        .default_vector(default_vector), .loader_base(loader_base), .sector_base(sector_base),
        .boot_to_loader(boot_to_loader), .serial_programming_mode(spm));
    bsas_programmer PRG (.clock(clock), .go(go), .hi_len(hi_len), .rst_pin(rst_pin));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict;
        $display("mismatches %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    task automatic cyc(input int k);
        repeat (k) @(posedge clock);
    endtask : cyc
    task automatic power_up;
        @(posedge clock);
        sys_rst <= 1'b1;
        cyc(10);
        sys_rst <= 1'b0;
    endtask : power_up
    // ==========
    // Start address selection, held inputs
    task automatic boot_once(input logic f, input bsas_byte_t v, input logic [1:0] s);
        bsas_byte_t d;
        int n;
        d = (s == 2'h0) ? 8'h0f : (s == 2'h1) ? 8'h1f : 8'h3f;
        n = 0;
        @(posedge clock);
        boot_status <= f;
        boot_vector <= v;
        mem_size <= s;
        core_rst <= 1'b1;
        cyc(3);
        #1 chk(fetch_enable, 0);
        @(posedge clock);
        core_rst <= 1'b0;
        do begin
            @(posedge clock);
            #1 n++;
        end while (pc_load !== 1'b1 && n < 20);
        chk(start_addr, f ? {v, 8'h00} : 16'h0000);
        chk(boot_to_loader, f && v == d);
        chk(default_vector, d);
        chk(loader_base, {d, 8'h00} - 16'h0100);
        chk(sector_base, {d, 8'h00} - 16'h0300);
        @(posedge clock);
        #1 chk({pc_load, fetch_enable}, 2'b01);
    endtask : boot_once
    // Reset pin pulse from the programmer
    task automatic pulse(input int lead, input logic [12:0] h, input logic exp);
        cyc(lead);
        hi_len <= h;
        go <= 1'b1;
        cyc(1);
        go <= 1'b0;
        cyc(h + 230);
        #1 chk(spm, exp);
    endtask : pulse
    initial begin
        power_up();
        boot_once(1'b0, 8'h1f, 2'h1);
        boot_once(1'b1, 8'h0f, 2'h0);
        boot_once(1'b1, 8'h1f, 2'h1);
        boot_once(1'b1, 8'h3f, 2'h2);
        boot_once(1'b1, 8'h3f, 2'h3);
        boot_once(1'b1, 8'h2a, 2'h1);
        boot_once(1'b1, 8'h00, 2'h0);
        pulse(100, 13'd400, 1'b0);
        power_up();
        pulse(10100, 13'd150, 1'b0);
        power_up();
        pulse(10100, 13'd6400, 1'b1);
        power_up();
        pulse(10100, 13'd200, 1'b1);
        power_up();
        pulse(10100, 13'd199, 1'b0);
        power_up();
        pulse(10100, 13'd6401, 1'b0);
        give_verdict();
    end
    initial begin
        cyc(80000);
        err_count++;
        give_verdict();
    end
endmodule : bsas_select_tb
bind bsas_select bsas_checker CHK (.clock(clock), .sys_rst(sys_rst), .core_rst(core_rst),
    .rst_pin(rst_pin), .boot_status(boot_status), .boot_vector(boot_vector),
    .mem_size(mem_size), .start_addr(start_addr), .pc_load(pc_load),
    .fetch_enable(fetch_enable), .default_vector(default_vector), .loader_base(loader_base),
    .sector_base(sector_base), .boot_to_loader(boot_to_loader),
    .serial_programming_mode(serial_programming_mode));
